// ==== common/rsiu_pkg.sv ====
// Constants shared by the reset status and interrupt unit.
// Assumes a 32-bit APB register bus and a core that issues one-cycle op pulses.
package rsiu_pkg;

  // APB register byte offsets.
  localparam logic [7:0] RSIU_OFS_RSTAT = 8'h00;
  localparam logic [7:0] RSIU_OFS_ISTAT = 8'h04;
  localparam logic [7:0] RSIU_OFS_IMASK = 8'h08;
  localparam logic [7:0] RSIU_OFS_P6CFG = 8'h0C;
  localparam logic [7:0] RSIU_OFS_P6RD  = 8'h10;
  localparam logic [7:0] RSIU_OFS_TICK  = 8'h14;

  // Reset status register fields.
  localparam int RSIU_RSTAT_TIMEOUT = 0;
  localparam int RSIU_RSTAT_PWRDN   = 1;
  localparam int RSIU_RSTAT_SLEEP   = 2;
  localparam int RSIU_RSTAT_GIE     = 3;

  // Interrupt status and mask fields.
  localparam int RSIU_IRQ_W    = 3;
  localparam int RSIU_IRQ_TICK = 0;
  localparam int RSIU_IRQ_PCHG = 1;
  localparam int RSIU_IRQ_EXT  = 2;

  // Port 6 configuration fields.
  localparam int RSIU_P6_W      = 8;
  localparam int RSIU_P6CFG_EXT = 8;

  // Tick counter control and count fields.
  localparam int RSIU_TICK_EN = 0;
  localparam int RSIU_TICK_CNT = 8;

  // Reset values.
  localparam logic [RSIU_IRQ_W-1:0] RSIU_IRQ_RST  = 3'h0;
  localparam logic [RSIU_P6_W-1:0]  RSIU_DIR_RST  = 8'h00;
  localparam logic [31:0]           RSIU_ZERO32   = 32'h0000_0000;

  // Fetch vectors.
  localparam int RSIU_PC_W = 10;
  localparam logic [RSIU_PC_W-1:0] RSIU_VEC_IRQ  = 10'h008;
  localparam logic [RSIU_PC_W-1:0] RSIU_VEC_SOFT = 10'h001;

  // Core power state.
  typedef enum logic [1:0] {
    RSIU_RUN   = 2'b01,
    RSIU_SLEEP = 2'b10
  } rsiu_state_e;

endpackage

// ==== verilog/rsiu_sync.sv ====
// Two-stage synchroniser for a bus of independent level inputs.
// Assumes each bit is an unrelated asynchronous level from a pin.
`timescale 1ns/1ps
module rsiu_sync #(
  parameter int WIDTH = 1
) (
  // Clock and reset.
  input  wire logic             core_clk,
  input  wire logic             sys_rst,
  // Asynchronous input and synchronised output.
  input  wire logic [WIDTH-1:0] asyncIn,
  output logic      [WIDTH-1:0] syncOut
);

  logic [WIDTH-1:0] stage1;

  generate
    if (WIDTH < 1) begin : g_badWidth
      $error("rsiu_sync: WIDTH must be at least 1");
    end
  endgenerate

  // Stage one feeds stage two and nothing else.
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      stage1  <= '1;
      syncOut <= '1;
    end else begin
      stage1  <= asyncIn;
      syncOut <= stage1;
    end
  end

endmodule // rsiu_sync

// ==== verilog/rsiu_tick_counter.sv ====
// Free-running tick counter with a prescaler enable and wrap pulse.
// Assumes the enable is a register bit on the same clock.
`timescale 1ns/1ps
module rsiu_tick_counter #(
  parameter int WIDTH    = 8,
  parameter int PRESCALE = 4
) (
  // Clock and reset.
  input  wire logic             core_clk,
  input  wire logic             sys_rst,
  // Control.
  input  wire logic             countEn,
  // State and wrap event.
  output logic      [WIDTH-1:0] count,
  output logic                  wrapPulse
);

  localparam int PRE_W = (PRESCALE > 1) ? $clog2(PRESCALE) : 1;
  localparam logic [PRE_W-1:0] PRE_LAST = PRE_W'(PRESCALE - 1);
  localparam logic [WIDTH-1:0] CNT_MAX  = '1;

  logic [PRE_W-1:0] preCnt;
  logic             stepEn;

  generate
    if (WIDTH < 1 || PRESCALE < 1) begin : g_badParam
      $error("rsiu_tick_counter: WIDTH and PRESCALE must be at least 1");
    end
  endgenerate

  // Prescaler gives a one-cycle step enable.
  assign stepEn = countEn && (preCnt == PRE_LAST);

  always_ff @(posedge core_clk) begin
    if (sys_rst || !countEn || stepEn) begin
      preCnt <= '0;
    end else begin
      preCnt <= preCnt + PRE_W'(1);
    end
  end

  // Wrap pulse stands in the cycle whose edge takes the counter to zero.
  assign wrapPulse = stepEn && (count == CNT_MAX);

  // Counter steps on the prescaler enable.
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      count <= '0;
    end else if (stepEn) begin
      count <= count + WIDTH'(1);
    end
  end

endmodule // rsiu_tick_counter

// ==== verilog/rsiu_top.sv ====
// Reset status flags and interrupt control for a small processor core.
// Assumes an APB master on core_clk, one-cycle op pulses from the core,
// a watchdog expiry pulse on core_clk, and asynchronous port pins.
//
// Operation
// R1: Reset from power, reset pin, watchdog.
// R2: Power-on sets timeout and power-down flags.
// R3: Running reset-pin reset keeps both flags.
// R4: Reset-pin wake: timeout set, power-down cleared.
// R5: Running watchdog reset: timeout cleared, power-down kept.
// R6: Watchdog wake clears both flags.
// R7: Pin-change wake: timeout set, power-down cleared.
// R8: Clear-op, sleep-op, expiry update flags.
// R9: Three interrupt sources: tick, change, external.
// R10: Change detector skips outputs, external pin.
// R11: Software reads port before enabling change.
// R12: Change wakes; vector only if enabled.
// R13: Enabled interrupt fetches from 008H.
// R14: Enable and disable ops drive global enable.
// R15: Flags set regardless of mask, except change.
// R16: Request equals status AND mask.
// R17: Return op sets global enable.
// R18: Software interrupt fetches from 001H.
// R19: Software clears serviced flag before return.
// R20: Tick flag sets in the wrap cycle.
`timescale 1ns/1ps
module rsiu_top
  import rsiu_pkg::*;
#(
  parameter int TICK_W        = 8,
  parameter int TICK_PRESCALE = 4
) (
  // Clock and reset; sys_rst is the power-on reset.
  input  wire logic                  core_clk,
  input  wire logic                  sys_rst,
  // APB slave.
  input  wire logic                  psel,
  input  wire logic                  penable,
  input  wire logic                  pwrite,
  input  wire logic [7:0]            paddr,
  input  wire logic [31:0]           pwdata,
  output logic      [31:0]           prdata,
  output logic                       pready,
  output logic                       pslverr,
  // Core op pulses.
  input  wire logic                  watchdogClearOp,
  input  wire logic                  sleepEntryOp,
  input  wire logic                  globalIrqEnableOp,
  input  wire logic                  globalIrqDisableOp,
  input  wire logic                  returnFromIrqOp,
  input  wire logic                  softIrqOp,
  // Watchdog and pins.
  input  wire logic                  watchdogExpire,
  input  wire logic                  resetPinN,
  input  wire logic [RSIU_P6_W-1:0]  port6Pin,
  // Core control.
  output logic                       coreReset,
  output logic                       coreWake,
  output logic                       fetchRedirect,
  output logic      [RSIU_PC_W-1:0]  fetchVector,
  output logic                       sleeping,
  output logic                       timeoutFlag,
  output logic                       powerDownFlag,
  output logic                       irqRequest
);

  generate
    if (TICK_W < 1 || TICK_W > 32 - RSIU_TICK_CNT) begin : g_badTick
      $error("rsiu_top: TICK_W must fit above the count field position");
    end
  endgenerate

  rsiu_state_e state_reg;
  rsiu_state_e state_next;

  logic [RSIU_IRQ_W-1:0] irq_status_reg;
  logic [RSIU_IRQ_W-1:0] irq_mask_reg;
  logic [RSIU_P6_W-1:0]  p6Dir_reg;
  logic                  extSel_reg;
  logic [RSIU_P6_W-1:0]  p6Ref_reg;
  logic                  tickEn_reg;
  logic                  gie_reg;
  logic                  rstPinPrev_reg;
  logic                  extPrev_reg;
  logic [RSIU_P6_W-1:0]  p6Sync;
  logic                  rstPinSync;
  logic [TICK_W-1:0]     tickCount;
  logic                  tickWrap;
  logic                  apbAccess;
  logic                  apbWrite;
  logic                  apbRead;
  logic [RSIU_P6_W-1:0]  watchMask;
  logic                  pinChange;
  logic                  extFall;
  logic                  pinResetEv;
  logic                  wdResetEv;
  logic                  hwResetEv;
  logic                  changeWake;
  logic [RSIU_IRQ_W-1:0] irqSet;
  logic [RSIU_IRQ_W-1:0] pending;
  logic                  irqTake;

  // Decode a register offset into a legal flag.
  function automatic logic isMapped(input logic [7:0] addr);
    case (addr)
      RSIU_OFS_RSTAT, RSIU_OFS_ISTAT, RSIU_OFS_IMASK,
      RSIU_OFS_P6CFG, RSIU_OFS_P6RD, RSIU_OFS_TICK: isMapped = 1'b1;
      default: isMapped = 1'b0;
    endcase
  endfunction

  // Pin synchronisers.
  rsiu_sync #(
    .WIDTH (RSIU_P6_W + 1)
  ) u_pinSync (
    .core_clk (core_clk),
    .sys_rst  (sys_rst),
    .asyncIn  ({resetPinN, port6Pin}),
    .syncOut  ({rstPinSync, p6Sync})
  );

  // Tick counter source.
  rsiu_tick_counter #(
    .WIDTH    (TICK_W),
    .PRESCALE (TICK_PRESCALE)
  ) u_tick (
    .core_clk  (core_clk),
    .sys_rst   (sys_rst),
    .countEn   (tickEn_reg),
    .count     (tickCount),
    .wrapPulse (tickWrap)
  );

  // APB access decode; a transfer completes when pready is seen high.
  assign apbAccess = psel && penable && !pready;
  assign apbWrite  = apbAccess && pwrite && isMapped(paddr);
  assign apbRead   = apbAccess && !pwrite;

  // Reset sources beyond power-on.
  // R1: reset sources.
  assign pinResetEv = rstPinSync && !rstPinPrev_reg;
  assign wdResetEv  = watchdogExpire;
  assign hwResetEv  = pinResetEv || wdResetEv;

  // Change detection on watched input pins only.
  // R10: excluded pins.
  assign watchMask = ~p6Dir_reg
                   & ~{{(RSIU_P6_W-1){1'b0}}, extSel_reg};
  assign pinChange = |((p6Sync ^ p6Ref_reg) & watchMask);

  // External interrupt fires on a falling edge of bit 0 when selected.
  assign extFall = extSel_reg && extPrev_reg && !p6Sync[0];

  // Wake from sleep by an enabled change source.
  // R12: change wake.
  assign changeWake = (state_reg == RSIU_SLEEP) && pinChange
                    && irq_mask_reg[RSIU_IRQ_PCHG];

  // Interrupt events; the change flag needs its mask bit.
  // R9: three sources.
  // R15: mask-free setting.
  // R20: tick wrap.
  always_comb begin
    irqSet                = '0;
    irqSet[RSIU_IRQ_TICK] = tickWrap;
    irqSet[RSIU_IRQ_PCHG] = pinChange && irq_mask_reg[RSIU_IRQ_PCHG];
    irqSet[RSIU_IRQ_EXT]  = extFall;
  end

  // Request presented to the core.
  // R16: status AND mask.
  assign pending = irq_status_reg & irq_mask_reg;
  assign irqTake = gie_reg && (|pending) && (state_reg == RSIU_RUN);

  // Edge history registers.
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      rstPinPrev_reg <= 1'b1;
      extPrev_reg    <= 1'b1;
    end else begin
      rstPinPrev_reg <= rstPinSync;
      extPrev_reg    <= p6Sync[0];
    end
  end

  // Power state machine.
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      RSIU_RUN: begin
        if (sleepEntryOp && !hwResetEv) begin
          state_next = RSIU_SLEEP;
        end
      end
      RSIU_SLEEP: begin
        if (hwResetEv || changeWake) begin
          state_next = RSIU_RUN;
        end
      end
      default: state_next = RSIU_RUN;
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      state_reg <= RSIU_RUN;
    end else begin
      state_reg <= state_next;
    end
  end

  // Timeout and power-down flags.
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      // R2: power-on values.
      timeoutFlag   <= 1'b1;
      powerDownFlag <= 1'b1;
    end else if (wdResetEv) begin
      // R5: running watchdog reset.
      // R6: watchdog wake.
      timeoutFlag <= 1'b0;
      if (state_reg == RSIU_SLEEP) begin
        powerDownFlag <= 1'b0;
      end
    end else if (pinResetEv) begin
      // R3: running pin reset holds.
      // R4: pin wake.
      if (state_reg == RSIU_SLEEP) begin
        timeoutFlag   <= 1'b1;
        powerDownFlag <= 1'b0;
      end
    end else if (changeWake) begin
      // R7: change wake.
      timeoutFlag   <= 1'b1;
      powerDownFlag <= 1'b0;
    end else if (watchdogClearOp) begin
      // R8: clear op.
      timeoutFlag   <= 1'b1;
      powerDownFlag <= 1'b1;
    end else if (sleepEntryOp && state_reg == RSIU_RUN) begin
      // R8: sleep op.
      timeoutFlag   <= 1'b1;
      powerDownFlag <= 1'b0;
    end
  end

  // Global interrupt enable; taking an interrupt, or a vectored wake, clears it.
  always_ff @(posedge core_clk) begin
    if (sys_rst || hwResetEv) begin
      gie_reg <= 1'b0;
    end else if (globalIrqDisableOp || irqTake || changeWake) begin
      // R14: disable op.
      gie_reg <= 1'b0;
    end else if (globalIrqEnableOp || returnFromIrqOp) begin
      // R14: enable op.
      // R17: return op.
      gie_reg <= 1'b1;
    end
  end

  // Interrupt status; a hardware set wins over a software clear.
  always_ff @(posedge core_clk) begin
    if (sys_rst || hwResetEv) begin
      irq_status_reg <= RSIU_IRQ_RST;
    end else if (apbWrite && paddr == RSIU_OFS_ISTAT) begin
      irq_status_reg <= pwdata[RSIU_IRQ_W-1:0] | irqSet;
    end else begin
      irq_status_reg <= irq_status_reg | irqSet;
    end
  end

  // Interrupt mask.
  always_ff @(posedge core_clk) begin
    if (sys_rst || hwResetEv) begin
      irq_mask_reg <= RSIU_IRQ_RST;
    end else if (apbWrite && paddr == RSIU_OFS_IMASK) begin
      irq_mask_reg <= pwdata[RSIU_IRQ_W-1:0];
    end
  end

  // Port 6 direction, external select and tick enable.
  always_ff @(posedge core_clk) begin
    if (sys_rst || hwResetEv) begin
      p6Dir_reg  <= RSIU_DIR_RST;
      extSel_reg <= 1'b0;
      tickEn_reg <= 1'b0;
    end else if (apbWrite && paddr == RSIU_OFS_P6CFG) begin
      p6Dir_reg  <= pwdata[RSIU_P6_W-1:0];
      extSel_reg <= pwdata[RSIU_P6CFG_EXT];
    end else if (apbWrite && paddr == RSIU_OFS_TICK) begin
      tickEn_reg <= pwdata[RSIU_TICK_EN];
    end
  end

  // Change reference is captured when software reads the port.
  // R11: read arms detector.
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      p6Ref_reg <= '0;
    end else if (apbRead && paddr == RSIU_OFS_P6RD) begin
      p6Ref_reg <= p6Sync;
    end
  end

  // Core control outputs.
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      coreReset     <= 1'b1;
      coreWake      <= 1'b0;
      fetchRedirect <= 1'b0;
      fetchVector   <= RSIU_VEC_IRQ;
      irqRequest    <= 1'b0;
    end else begin
      // R1: core reset pulse.
      coreReset     <= hwResetEv;
      coreWake      <= changeWake;
      irqRequest    <= |pending;
      fetchRedirect <= 1'b0;
      if (changeWake && gie_reg) begin
        // R12: wake vectors when enabled.
        fetchRedirect <= 1'b1;
        fetchVector   <= RSIU_VEC_IRQ;
      end else if (irqTake && !hwResetEv) begin
        // R13: interrupt vector.
        fetchRedirect <= 1'b1;
        fetchVector   <= RSIU_VEC_IRQ;
      end else if (softIrqOp && state_reg == RSIU_RUN && !hwResetEv) begin
        // R18: software vector.
        fetchRedirect <= 1'b1;
        fetchVector   <= RSIU_VEC_SOFT;
      end
    end
  end

  // Sleep state shown to the core.
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      sleeping <= 1'b0;
    end else begin
      sleeping <= (state_next == RSIU_SLEEP);
    end
  end

  // APB answer: one wait state, registered data and error.
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= RSIU_ZERO32;
    end else begin
      pready  <= apbAccess;
      pslverr <= apbAccess && !isMapped(paddr);
      prdata  <= RSIU_ZERO32;
      if (apbRead) begin
        case (paddr)
          RSIU_OFS_RSTAT: begin
            prdata[RSIU_RSTAT_TIMEOUT] <= timeoutFlag;
            prdata[RSIU_RSTAT_PWRDN]   <= powerDownFlag;
            prdata[RSIU_RSTAT_SLEEP]   <= (state_reg == RSIU_SLEEP);
            prdata[RSIU_RSTAT_GIE]     <= gie_reg;
          end
          RSIU_OFS_ISTAT: prdata[RSIU_IRQ_W-1:0] <= irq_status_reg;
          RSIU_OFS_IMASK: prdata[RSIU_IRQ_W-1:0] <= irq_mask_reg;
          RSIU_OFS_P6CFG: begin
            prdata[RSIU_P6_W-1:0]   <= p6Dir_reg;
            prdata[RSIU_P6CFG_EXT]  <= extSel_reg;
          end
          RSIU_OFS_P6RD:  prdata[RSIU_P6_W-1:0] <= p6Sync;
          RSIU_OFS_TICK: begin
            prdata[RSIU_TICK_EN]    <= tickEn_reg;
            prdata[RSIU_TICK_CNT +: TICK_W] <= tickCount;
          end
          default: prdata <= RSIU_ZERO32;
        endcase
      end
    end
  end

endmodule // rsiu_top

// ==== testbench/rsiu_props.sv ====
// Checker for the reset status and interrupt unit.
// Assumes it is bound to rsiu_top and sees only its ports.
`timescale 1ns/1ps
module rsiu_props
  import rsiu_pkg::*;
(
  // Watched ports.
  input wire logic                 core_clk,
  input wire logic                 sys_rst,
  input wire logic                 watchdogExpire,
  input wire logic                 watchdogClearOp,
  input wire logic                 sleepEntryOp,
  input wire logic                 softIrqOp,
  input wire logic                 coreReset,
  input wire logic                 coreWake,
  input wire logic                 fetchRedirect,
  input wire logic [RSIU_PC_W-1:0] fetchVector,
  input wire logic                 sleeping,
  input wire logic                 timeoutFlag,
  input wire logic                 powerDownFlag
);
  // Power-on reset sets both flags.
  property p_por;
    @(posedge core_clk) sys_rst |=> timeoutFlag && powerDownFlag;
  endproperty
  a_por: assert property (p_por) else $error("flags not set by power-on");
  // Expiry restarts the core.
  property p_wd_rst;
    @(posedge core_clk) disable iff (sys_rst) watchdogExpire |-> ##[1:2] coreReset;
  endproperty
  a_wd_rst: assert property (p_wd_rst) else $error("no core reset on expiry");
  // Expiry while running clears timeout and keeps power-down.
  property p_wd_run;
    @(posedge core_clk) disable iff (sys_rst) watchdogExpire && !sleeping
      |=> !timeoutFlag && powerDownFlag == $past(powerDownFlag);
  endproperty
  a_wd_run: assert property (p_wd_run) else $error("bad flags on running expiry");
  // Expiry in sleep clears both flags.
  property p_wd_slp;
    @(posedge core_clk) disable iff (sys_rst) watchdogExpire && sleeping
      |=> !timeoutFlag && !powerDownFlag;
  endproperty
  a_wd_slp: assert property (p_wd_slp) else $error("bad flags on expiry wake");
  // Clear op sets both flags.
  property p_clr;
    @(posedge core_clk) disable iff (sys_rst) watchdogClearOp && !watchdogExpire
      |=> timeoutFlag && powerDownFlag;
  endproperty
  a_clr: assert property (p_clr) else $error("bad flags after clear op");
  // Sleep op enters sleep with timeout set and power-down cleared.
  property p_slp;
    @(posedge core_clk) disable iff (sys_rst) sleepEntryOp && !watchdogExpire && !coreReset
      |=> sleeping && timeoutFlag && !powerDownFlag;
  endproperty
  a_slp: assert property (p_slp) else $error("bad state after sleep op");
  // Change wake leaves the core running with timeout set.
  property p_wake;
    @(posedge core_clk) disable iff (sys_rst) coreWake
      |-> ##[0:1] (timeoutFlag && !powerDownFlag && !sleeping);
  endproperty
  a_wake: assert property (p_wake) else $error("bad state after change wake");
  // Software interrupt fetches from the soft vector.
  property p_soft;
    @(posedge core_clk) disable iff (sys_rst) softIrqOp && !sleeping && !watchdogExpire
      |=> fetchRedirect && fetchVector == RSIU_VEC_SOFT;
  endproperty
  a_soft: assert property (p_soft) else $error("soft op did not redirect");
  // Any other redirect goes to the interrupt vector.
  property p_vec;
    @(posedge core_clk) disable iff (sys_rst) fetchRedirect && !$past(softIrqOp)
      |-> fetchVector == RSIU_VEC_IRQ;
  endproperty
  a_vec: assert property (p_vec) else $error("wrong interrupt vector");
endmodule // rsiu_props

bind rsiu_top rsiu_props i_props (
  .core_clk(core_clk), .sys_rst(sys_rst), .watchdogExpire(watchdogExpire),
  .watchdogClearOp(watchdogClearOp), .sleepEntryOp(sleepEntryOp), .softIrqOp(softIrqOp),
  .coreReset(coreReset), .coreWake(coreWake), .fetchRedirect(fetchRedirect),
  .fetchVector(fetchVector), .sleeping(sleeping), .timeoutFlag(timeoutFlag),
  .powerDownFlag(powerDownFlag)
);

// ==== testbench/rsiu_core_model.sv ====
// Core sequencer model: issues op pulses and records fetch redirects.
// Assumes bench requests arrive as one-cycle pulses on core_clk.
`timescale 1ns/1ps
module rsiu_core_model
  import rsiu_pkg::*;
(
  // Clock and reset.
  input  wire logic                 core_clk,
  input  wire logic                 sys_rst,
  // Op requests and fetch control.
  input  wire logic [5:0]           opReq,
  input  wire logic                 fetchRedirect,
  input  wire logic [RSIU_PC_W-1:0] fetchVector,
  // Op pulses to the unit.
  output logic                      watchdogClearOp,
  output logic                      sleepEntryOp,
  output logic                      globalIrqEnableOp,
  output logic                      globalIrqDisableOp,
  output logic                      returnFromIrqOp,
  output logic                      softIrqOp,
  // Record of redirects.
  output int                        redirectCount,
  output logic      [RSIU_PC_W-1:0] lastVector
);
  // A core held in reset issues no ops.
  assign {softIrqOp, returnFromIrqOp, globalIrqDisableOp, globalIrqEnableOp, sleepEntryOp,
          watchdogClearOp} = sys_rst ? 6'h00 : opReq;
  // Each redirect is counted with its vector.
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      redirectCount <= 0;
    end else if (fetchRedirect) begin
      redirectCount <= redirectCount + 1;
      lastVector    <= fetchVector;
    end
  end
endmodule // rsiu_core_model

// ==== testbench/testbench.sv ====
// Self-checking bench for the reset status and interrupt unit.
// Assumes the core model issues ops and the bench drives APB and pins.
`timescale 1ns/1ps
module testbench;
  import rsiu_pkg::*;
  localparam int CLR = 0, SLP = 1, ION = 2, DIS = 3, RET = 4, SW = 5;
  logic core_clk, sys_rst, psel, penable, pwrite, pready, pslverr, err;
  logic [7:0] paddr, port6Pin;
  logic [31:0] pwdata, prdata, rd;
  logic wdX, rstN, wcO, seO, geO, gdO, rfO, siO;
  logic cRst, cWake, fRed, slp, tF, pF, irq, expT, expP;
  logic [5:0] opReq;
  logic [RSIU_PC_W-1:0] fVec, lastVec;
  int redirCount, expRedir, rstSeen, b, fail_count, n_compared;
  logic [2:0] s, m;

  rsiu_top #(.TICK_W(4), .TICK_PRESCALE(2)) i_dut (
    .core_clk(core_clk), .sys_rst(sys_rst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .watchdogClearOp(wcO), .sleepEntryOp(seO),
    .globalIrqEnableOp(geO), .globalIrqDisableOp(gdO), .returnFromIrqOp(rfO),
    .softIrqOp(siO), .watchdogExpire(wdX), .resetPinN(rstN), .port6Pin(port6Pin),
    .coreReset(cRst), .coreWake(cWake), .fetchRedirect(fRed), .fetchVector(fVec),
    .sleeping(slp), .timeoutFlag(tF), .powerDownFlag(pF), .irqRequest(irq));
  rsiu_core_model i_core (
    .core_clk(core_clk), .sys_rst(sys_rst), .opReq(opReq), .fetchRedirect(fRed),
    .fetchVector(fVec), .watchdogClearOp(wcO), .sleepEntryOp(seO),
    .globalIrqEnableOp(geO), .globalIrqDisableOp(gdO), .returnFromIrqOp(rfO),
    .softIrqOp(siO), .redirectCount(redirCount), .lastVector(lastVec));

  // Clock at 100 ns period.
  initial begin
    core_clk = 0;
    forever #50 core_clk = ~core_clk;
  end
  // Core resets seen after power-on.
  always @(posedge core_clk) if (!sys_rst && cRst) rstSeen++;

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      fail_count++;
      $display("mismatch at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge core_clk);
    psel <= 1; penable <= 0; pwrite <= wr; paddr <= a; pwdata <= d;
    @(posedge core_clk);
    penable <= 1;
    do begin @(posedge core_clk); n++; end while (pready !== 1'b1 && n < 20);
    if (n >= 20) chk(0, 1);
    rd = prdata;
    err = pslverr;
    psel <= 0;
    penable <= 0;
  endtask
  task automatic op(input int i);
    @(posedge core_clk);
    opReq <= 6'(1 << i);
    @(posedge core_clk);
    opReq <= 6'h00;
    repeat (3) @(posedge core_clk);
  endtask
  task automatic wdog;
    @(posedge core_clk);
    wdX <= 1;
    @(posedge core_clk);
    wdX <= 0;
    repeat (3) @(posedge core_clk);
  endtask
  task automatic pin_rst;
    @(posedge core_clk);
    rstN <= 0;
    repeat (4) @(posedge core_clk);
    rstN <= 1;
    repeat (8) @(posedge core_clk);
  endtask
  task automatic pins(input logic [7:0] v);
    @(posedge core_clk);
    port6Pin <= v;
    repeat (8) @(posedge core_clk);
  endtask
  task automatic flags;
    chk(32'({tF, pF}), 32'({expT, expP}));
  endtask
  task automatic redir(input logic [RSIU_PC_W-1:0] v, input int inc);
    expRedir += inc;
    chk(32'(redirCount), 32'(expRedir));
    if (inc > 0) chk(32'(lastVec), 32'(v));
  endtask
  task automatic finish_test;
    $display("compared %0d, mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  // Hang guard.
  initial begin
    repeat (5000) @(posedge core_clk);
    fail_count++;
    finish_test();
  end
  // Main sequence.
  initial begin
    {psel, penable, pwrite, paddr, pwdata, wdX, port6Pin, opReq} = '0;
    {rstN, sys_rst} = 2'b11;
    expRedir = 0;
    void'($urandom(25));
    repeat (3) @(posedge core_clk);
    sys_rst <= 0;
    apb(0, RSIU_OFS_RSTAT, 0);
    chk(rd, 32'h0000_0003); // flags
    apb(1, 8'h40, 32'h0000_0007);
    chk(32'(err), 32'h0000_0001);
    chk(rd, 32'h0000_0000);
    apb(0, RSIU_OFS_P6RD, 0);
    for (int k = 0; k < 6; k++) begin
      s = 3'($urandom);
      m = 3'($urandom);
      apb(1, RSIU_OFS_ISTAT, 32'(s));
      apb(1, RSIU_OFS_IMASK, 32'(m));
      apb(0, RSIU_OFS_ISTAT, 0);
      chk(rd, 32'(s));
      chk(32'(irq), 32'(|(s & m)));
    end
    apb(1, RSIU_OFS_ISTAT, 0);
    apb(1, RSIU_OFS_IMASK, 1);
    op(ION);
    op(DIS);
    apb(1, RSIU_OFS_ISTAT, 1);
    redir(RSIU_VEC_IRQ, 0);
    op(RET);
    redir(RSIU_VEC_IRQ, 1);
    apb(1, RSIU_OFS_ISTAT, 0);
    apb(1, RSIU_OFS_ISTAT, 1);
    op(ION);
    redir(RSIU_VEC_IRQ, 1);
    apb(1, RSIU_OFS_ISTAT, 0);
    op(SW);
    redir(RSIU_VEC_SOFT, 1);
    apb(1, RSIU_OFS_IMASK, 0);
    apb(1, RSIU_OFS_TICK, 1);
    repeat (50) @(posedge core_clk);
    apb(1, RSIU_OFS_TICK, 0);
    apb(0, RSIU_OFS_ISTAT, 0);
    chk(32'({rd[0], irq}), 32'h0000_0002);
    apb(1, RSIU_OFS_ISTAT, 0);
    apb(1, RSIU_OFS_IMASK, 2);
    op(SLP);
    pins(8'h08);
    expT = 1;
    expP = 0;
    flags();
    chk(32'(slp), 0);
    redir(RSIU_VEC_IRQ, 0);
    apb(0, RSIU_OFS_P6RD, 0);
    apb(1, RSIU_OFS_ISTAT, 0);
    op(ION);
    op(SLP);
    pins(8'h00);
    redir(RSIU_VEC_IRQ, 1);
    apb(0, RSIU_OFS_P6RD, 0);
    apb(1, RSIU_OFS_ISTAT, 0);
    apb(1, RSIU_OFS_P6CFG, 32'h0000_0110);
    op(SLP);
    pins(8'h11);
    chk(32'(slp), 1);
    wdog();
    expT = 0;
    flags();
    op(CLR);
    expT = 1;
    expP = 1;
    flags();
    wdog();
    expT = 0;
    flags();
    b = rstSeen;
    pin_rst();
    flags();
    chk(32'(rstSeen - b), 1);
    op(SLP);
    expT = 1;
    expP = 0;
    pin_rst();
    flags();
    chk(32'(slp), 0);
    finish_test();
  end
endmodule // testbench
